// ===== verilog/ccmsr_clock_gen.sv
// Clock generation, clock monitor, stop sequencing and reset sequencer.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Core clock runs at twice bus clock; a processor cycle is one bus clock.
// - External bus clock pin is derived from the bus clock.
// - Self-clock mode replaces the oscillator with PLL at minimum frequency.
// - PLL select bit drives the system clock from the PLL.
// - PLL stays running while selected, even with power-on bit cleared.
// - Monitor disabled means oscillator loss is neither seen nor acted on.
// - Monitor on, self-clock off: loss causes immediate clock monitor reset.
// - Loss in wait with self-clock: enter self-clock, start check, set flag.
// - Recovery: clock good after 4096 oscillator cycles, leave self-clock.
// - Wakeup after recovery runs on oscillator; reset starts reset sequence.
// - Without recovery, checks repeat and wakeup exits in self-clock mode.
// - With self-clock interrupt enabled, loss raises flag and wakeup request.
// - Stop halts clocks, oscillator off unless pseudo-stop; dividers freeze.
// - Pseudo-stop keeps tick counter or watchdog running when enabled.
// - Stop requests the voltage regulator to enter low power.
// - Stop entry: clear PLL select, then PLL off, core off, system off.
// - Pseudo-stop from self-clock keeps checking with PLL and regulator on.
// - Full stop from self-clock aborts check, restarts it after stop exit.
// - Internal reset holds for 192 system clocks, released synchronously.
// - External reset pin held low keeps the internal reset asserted.
// - Monitor reset sets defaults, enters self-clock, starts reset and check.
// - Good check switches to oscillator even during the reset sequence.
// - Reset end fetches monitor vector when a monitor failure was latched.
module ccmsr_clock_gen #(
  parameter int QC_LEN = ccmsr_pkg::QC_OSC_CYCLES
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic osc_clk_in,
  input wire logic pll_clk_in,
  input wire logic ext_reset_n_in,
  input wire logic stop_req_in,
  input wire logic wait_in,
  input wire logic wakeup_in,
  output logic core_clk_en_out,
  output logic bus_clk_en_out,
  output logic ext_bus_clk_out,
  output logic pll_enable_out,
  output logic pll_min_freq_out,
  output logic osc_enable_out,
  output logic voltage_regulator_low_power_out,
  output logic tick_run_out,
  output logic watchdog_run_out,
  output logic internal_reset_out,
  output logic cm_vector_out,
  output logic self_clock_mode_out,
  output logic scm_wakeup_out,
  output logic stop_active_out
);
  import ccmsr_pkg::*;

  function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] o);
    reg_hit = (a == o);
  endfunction

  ccmsr_src_if src ();
  ccmsr_src_mux u_mux (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .src(src)
  );

  // Pin synchronisers: ext reset, oscillator and PLL levels.
  wire logic [2:0] pin_raw = {pll_clk_in, osc_clk_in, ext_reset_n_in};
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          sync1[gi] <= (gi == 0);
          sync2[gi] <= (gi == 0);
          sync3[gi] <= (gi == 0);
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
    end
  endgenerate

  wire logic ext_rst_n = sync2[0];
  wire logic osc_tick = sync2[1] & ~sync3[1];
  wire logic pll_tick = sync2[2] & ~sync3[2];

  logic [7:0] ctrl;
  logic [7:0] pstop;
  logic flag;
  logic self_clock_mode;
  logic osc_good;
  logic cm_fail;
  logic qc_run;
  logic qc_pend;
  logic [12:0] qc_cnt;
  logic [15:0] loss_cnt;
  logic [7:0] rst_cnt;
  logic bus_phase;
  ccmsr_stop_e state;

  wire logic sel_pll = ctrl[C_PLL_SEL];
  wire logic clock_monitor_enable = ctrl[C_CM_EN];
  wire logic self_clock_mode_enable = ctrl[C_SCM_EN];
  wire logic self_clock_irq_enable = ctrl[C_SCM_IE];
  wire logic pseudo = ctrl[C_PSTOP];
  wire logic wr_ctrl = reg_wr_in & reg_hit(reg_addr_in, ADDR_CTRL);
  wire logic wr_pstop = reg_wr_in & reg_hit(reg_addr_in, ADDR_PSTOP);
  wire logic wr_stat = reg_wr_in & reg_hit(reg_addr_in, ADDR_STAT);
  wire logic flag_clr = wr_stat & reg_wdata_in[S_FLAG];
  wire logic wake = wakeup_in | ~ext_rst_n;

  wire logic in_stop_seq = (state != ST_RUN);
  wire logic core_off = (state == ST_COREOFF) | (state == ST_STOP);
  wire logic sys_off = (state == ST_STOP);
  wire logic full_stop = sys_off & ~pseudo;
  wire logic qc_freeze = in_stop_seq & ~pseudo;
  wire logic osc_en = ~full_stop;

  // Loss is only watched while the monitor is on and the oscillator runs.
  wire logic mon_on = clock_monitor_enable & osc_en;
  wire logic osc_lost = (loss_cnt == 16'(CM_TIMEOUT_CYC));
  wire logic loss_evt = mon_on & ~osc_tick &
                        (loss_cnt == 16'(CM_TIMEOUT_CYC - 1));
  wire logic cm_rst = loss_evt & ~self_clock_mode_enable;
  wire logic scm_enter = loss_evt & self_clock_mode_enable;
  wire logic rst_all = cm_rst | ~ext_rst_n;
  wire logic qc_done = qc_run & ~qc_freeze & osc_tick & ~osc_lost &
                       (qc_cnt == 13'(QC_LEN - 1));

  wire logic core_en = src.src_tick & ~core_off;
  wire logic bus_en = src.src_tick & bus_phase & ~sys_off;
  wire logic next_bus_phase = (src.src_tick & ~sys_off) ? ~bus_phase :
                              bus_phase;
  wire logic [7:0] next_rst_cnt =
    rst_all ? 8'h00 :
    ((src.src_tick && rst_cnt != RST_SEQ_LEN) ? rst_cnt + 8'h01 : rst_cnt);
  wire logic rst_done = (next_rst_cnt == RST_SEQ_LEN) &
                        (rst_cnt != RST_SEQ_LEN);
  wire logic [7:0] stat_word = {3'h0, src.on_pll, cm_fail, osc_good, self_clock_mode,
                                flag};
  wire logic [7:0] next_rdata =
    reg_hit(reg_addr_in, ADDR_CTRL) ? ctrl :
    reg_hit(reg_addr_in, ADDR_PSTOP) ? pstop :
    reg_hit(reg_addr_in, ADDR_STAT) ? stat_word : 8'h00;

  assign src.osc_tick = osc_tick;
  assign src.pll_tick = pll_tick;
  assign src.want_pll = sel_pll | self_clock_mode;

  // Stop entry walks the clocks down one step per cycle, but outside self-clock mode waits in ST_DESEL until the mux has left the PLL.
  always_ff @(posedge mclk_in) begin
    if (reset_in || rst_all) begin
      state <= ST_RUN;
    end else begin
      case (state)
        ST_RUN: begin
          if (stop_req_in) state <= ST_DESEL;
        end
        ST_DESEL: begin
          if (wake) state <= ST_RUN;
          else if (!src.on_pll || self_clock_mode) state <= ST_PLLOFF;
        end
        ST_PLLOFF: begin
          state <= wake ? ST_RUN : ST_COREOFF;
        end
        ST_COREOFF: begin
          state <= wake ? ST_RUN : ST_STOP;
        end
        ST_STOP: begin
          if (wake) state <= ST_RUN;
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // A monitor reset forces the defaults, which sets both monitor enables.
  always_ff @(posedge mclk_in) begin
    if (reset_in || rst_all) begin
      ctrl <= CTRL_RESET;
      pstop <= PSTOP_RESET;
    end else begin
      if (state == ST_DESEL) ctrl[C_PLL_SEL] <= 1'b0;
      else if (wr_ctrl) ctrl <= reg_wdata_in;
      if (wr_pstop) pstop <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in || !mon_on || osc_tick) loss_cnt <= 16'h0000;
    else if (!osc_lost) loss_cnt <= loss_cnt + 16'h0001;
  end

  // Self-clock mode and its flag; a set in the clear cycle wins.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      self_clock_mode <= 1'b0;
      flag <= 1'b0;
      osc_good <= 1'b0;
    end else begin
      if (scm_enter || cm_rst) self_clock_mode <= 1'b1;
      else if (qc_done) self_clock_mode <= 1'b0;
      if (scm_enter) flag <= 1'b1;
      else if (flag_clr || !ext_rst_n) flag <= 1'b0;
      if (loss_evt) osc_good <= 1'b0;
      else if (qc_done) osc_good <= 1'b1;
    end
  end

  // Quality check: counts oscillator ticks, restarts on any loss.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      qc_run <= 1'b0;
      qc_pend <= 1'b0;
      qc_cnt <= 13'h0000;
    end else begin
      if (scm_enter || cm_rst) begin
        qc_run <= 1'b1;
        qc_pend <= 1'b0;
      end else if (qc_done) begin
        qc_run <= 1'b0;
      end else if (qc_freeze && qc_run) begin
        qc_run <= 1'b0;
        qc_pend <= 1'b1;
      end else if (!qc_freeze && qc_pend) begin
        qc_run <= 1'b1;
        qc_pend <= 1'b0;
      end
      if (!qc_run || qc_freeze || osc_lost || qc_done) qc_cnt <= 13'h0000;
      else if (osc_tick) qc_cnt <= qc_cnt + 13'h0001;
    end
  end

  // The vector choice is made on the same edge the reset releases.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cm_fail <= 1'b0;
      rst_cnt <= 8'h00;
      internal_reset_out <= 1'b1;
      cm_vector_out <= 1'b0;
    end else begin
      if (cm_rst) cm_fail <= 1'b1;
      else if (!ext_rst_n) cm_fail <= 1'b0;
      rst_cnt <= next_rst_cnt;
      internal_reset_out <= (next_rst_cnt != RST_SEQ_LEN);
      if (rst_done) cm_vector_out <= cm_fail;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bus_phase <= 1'b0;
      ext_bus_clk_out <= 1'b0;
      reg_rdata_out <= 8'h00;
    end else begin
      bus_phase <= next_bus_phase;
      ext_bus_clk_out <= next_bus_phase;
      if (reg_rd_in) reg_rdata_out <= next_rdata;
    end
  end

  assign core_clk_en_out = core_en;
  assign bus_clk_en_out = bus_en;
  // Clearing the power bit cannot stop a selected PLL.
  assign pll_enable_out = in_stop_seq ? (state == ST_DESEL) |
                          (pseudo & self_clock_mode) :
                          (sel_pll | self_clock_mode | (ctrl[C_PLL_PWR] &
                          ~(wait_in & ctrl[C_PLL_WAI])));
  assign pll_min_freq_out = self_clock_mode;
  assign osc_enable_out = osc_en;
  assign voltage_regulator_low_power_out = sys_off & ~(pseudo & self_clock_mode);
  assign tick_run_out = ~sys_off | (pseudo & pstop[P_TICK_RUN]);
  assign watchdog_run_out = ~sys_off | (pseudo & pstop[P_WDOG_RUN]);
  assign self_clock_mode_out = self_clock_mode;
  assign scm_wakeup_out = flag & self_clock_irq_enable;
  assign stop_active_out = sys_off;

  sequence s_pll_dropped;
    state == ST_PLLOFF && !wake && !rst_all;
  endsequence
  sequence s_clocks_down;
    state == ST_COREOFF ##1 (state == ST_STOP || state == ST_RUN);
  endsequence
  property p_stop_chain;
    @(posedge mclk_in) disable iff (reset_in)
      s_pll_dropped |=> s_clocks_down;
  endproperty

  a_core_bus_ratio: assert property (@(posedge mclk_in)
    disable iff (reset_in) bus_en && !core_off |-> core_en ##1 !bus_en)
    else $error("bus tick without paired core tick");
  a_ext_from_bus: assert property (@(posedge mclk_in)
    disable iff (reset_in) bus_en |=> !ext_bus_clk_out)
    else $error("external bus clock not following bus clock");
  a_scm_src_pll: assert property (@(posedge mclk_in)
    disable iff (reset_in) self_clock_mode |-> src.want_pll && pll_enable_out ||
    in_stop_seq)
    else $error("self-clock mode not on the PLL");
  a_pll_kept_on: assert property (@(posedge mclk_in)
    disable iff (reset_in) sel_pll && !in_stop_seq |-> pll_enable_out)
    else $error("selected PLL was switched off");
  a_cm_off_quiet: assert property (@(posedge mclk_in)
    disable iff (reset_in) !clock_monitor_enable |-> !loss_evt && !cm_rst)
    else $error("loss acted on with monitor disabled");
  a_cm_reset_hit: assert property (@(posedge mclk_in)
    disable iff (reset_in) cm_rst |=> internal_reset_out && self_clock_mode &&
    cm_fail && ctrl[C_SCM_EN] ##1 internal_reset_out)
    else $error("monitor reset did not take effect");
  a_scm_entry: assert property (@(posedge mclk_in)
    disable iff (reset_in) scm_enter |=> self_clock_mode && flag && qc_run &&
    !$rose(internal_reset_out))
    else $error("self-clock entry incomplete");
  a_stop_order: assert property (p_stop_chain)
    else $error("stop sequence out of order");
  a_rst_hold_ext: assert property (@(posedge mclk_in)
    disable iff (reset_in) !ext_rst_n |=> internal_reset_out [*2])
    else $error("internal reset released under external reset");
  a_rst_length: assert property (@(posedge mclk_in)
    disable iff (reset_in) $fell(internal_reset_out) |->
    $past(rst_cnt) == RST_SEQ_LEN - 8'h01 && rst_cnt == RST_SEQ_LEN)
    else $error("reset sequence length wrong");
  a_qc_leave_scm: assert property (@(posedge mclk_in)
    disable iff (reset_in) qc_done && !scm_enter && !cm_rst |=>
    !self_clock_mode && osc_good)
    else $error("good check did not leave self-clock mode");
  a_cm_vector: assert property (@(posedge mclk_in)
    disable iff (reset_in) $fell(internal_reset_out) |->
    cm_vector_out == $past(cm_fail))
    else $error("wrong reset vector choice");
  a_pseudo_scm_on: assert property (@(posedge mclk_in)
    disable iff (reset_in) in_stop_seq && pseudo && self_clock_mode |->
    pll_enable_out && !voltage_regulator_low_power_out)
    else $error("pseudo-stop from self-clock lost PLL or regulator");
  a_full_stop_abort: assert property (@(posedge mclk_in)
    disable iff (reset_in) qc_freeze && qc_run && !scm_enter && !cm_rst
    |=> !qc_run && qc_pend)
    else $error("quality check not aborted in full stop");
endmodule // ccmsr_clock_gen
`default_nettype wire

// ===== include/ccmsr_pkg.sv
// Shared constants and types of the clock monitor, stop and reset generator.
package ccmsr_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CM_TIMEOUT_NS = 2000;
  localparam int CM_TIMEOUT_CYC = (CM_TIMEOUT_NS + CLK_PERIOD_NS - 1) /
                                  CLK_PERIOD_NS;
  localparam int QC_OSC_CYCLES = 4096;
  localparam logic [7:0] RST_SEQ_LEN = 8'hc0;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PSTOP = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [7:0] CTRL_RESET = 8'h0e;
  localparam logic [7:0] PSTOP_RESET = 8'h00;
  localparam int C_PLL_SEL = 0;
  localparam int C_PLL_PWR = 1;
  localparam int C_CM_EN = 2;
  localparam int C_SCM_EN = 3;
  localparam int C_SCM_IE = 4;
  localparam int C_PLL_WAI = 5;
  localparam int C_PSTOP = 6;
  localparam int P_TICK_RUN = 0;
  localparam int P_WDOG_RUN = 1;
  localparam int S_FLAG = 0;
  localparam int S_SCM = 1;
  localparam int S_OSC_GOOD = 2;
  localparam int S_CM_FAIL = 3;
  localparam int S_ON_PLL = 4;
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_DESEL = 5'h02,
    ST_PLLOFF = 5'h04,
    ST_COREOFF = 5'h08,
    ST_STOP = 5'h10
  } ccmsr_stop_e;
endpackage

// ===== include/ccmsr_src_if.sv
// Source selection signals between the generator and its clock mux.
`timescale 1ns/100ps
`default_nettype none
interface ccmsr_src_if;
  logic osc_tick;
  logic pll_tick;
  logic want_pll;
  logic on_pll;
  logic src_tick;
  modport mux (input osc_tick, input pll_tick, input want_pll,
               output on_pll, output src_tick);
  modport ctl (output osc_tick, output pll_tick, output want_pll,
               input on_pll, input src_tick);
endinterface
`default_nettype wire

// ===== verilog/ccmsr_src_mux.sv
// Glitch-free selection between oscillator and PLL clock ticks.
`timescale 1ns/100ps
`default_nettype none
module ccmsr_src_mux (
  input wire logic mclk_in,
  input wire logic reset_in,
  ccmsr_src_if.mux src
);
  logic cur;
  logic hold;
  wire logic new_tick = src.want_pll ? src.pll_tick : src.osc_tick;
  wire logic cur_tick = cur ? src.pll_tick : src.osc_tick;

  // The old source is cut at once and the new one passes only after its
  // own first whole tick, so no shortened period reaches the system.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cur <= 1'b0;
      hold <= 1'b0;
    end else if (src.want_pll != cur) begin
      cur <= src.want_pll;
      hold <= 1'b1;
    end else if (hold && new_tick) begin
      hold <= 1'b0;
    end
  end

  assign src.on_pll = cur;
  assign src.src_tick = cur_tick & ~hold & (src.want_pll == cur);
endmodule // ccmsr_src_mux
`default_nettype wire

// ===== tb/ccmsr_far_model.sv
// Far-side model: oscillator and PLL pins plus a clock-enable consumer.
`timescale 1ns/100ps
`default_nettype none
module ccmsr_far_model (
  input wire logic mclk_in,
  input wire logic osc_alive_in,
  input wire logic osc_en_in,
  input wire logic pll_en_in,
  input wire logic clr_in,
  input wire logic core_en_in,
  input wire logic bus_en_in,
  input wire logic ext_clk_in,
  output logic osc_clk_out,
  output logic pll_clk_out,
  output var int osc_ticks_out,
  output var int core_cnt_out,
  output var int bus_cnt_out,
  output var int ext_cnt_out
);
  logic osc = 1'b0;
  logic pll = 1'b0;
  logic osc_q = 1'b0;
  logic ext_q = 1'b0;
  assign osc_clk_out = osc;
  assign pll_clk_out = pll;
  // A failed or disabled source stops at a level. Half periods in steps of
  // 1.6 ns never land on a rising edge of the system clock, so no race.
  always #20.8 osc = osc_alive_in & osc_en_in & ~osc;
  always #28.8 pll = pll_en_in & ~pll;
  always @(posedge mclk_in) begin
    osc_q <= osc;
    ext_q <= ext_clk_in;
    if (clr_in) begin
      osc_ticks_out <= 0;
      core_cnt_out <= 0;
      bus_cnt_out <= 0;
      ext_cnt_out <= 0;
    end else begin
      osc_ticks_out <= osc_ticks_out + int'(osc & ~osc_q);
      core_cnt_out <= core_cnt_out + int'(core_en_in);
      bus_cnt_out <= bus_cnt_out + int'(bus_en_in);
      ext_cnt_out <= ext_cnt_out + int'(ext_clk_in ^ ext_q);
    end
  end
endmodule // ccmsr_far_model
`default_nettype wire

// ===== tb/tb_clock_monitor_stop_reset_gen.sv
// Self-checking bench for the clock monitor, stop and reset generator.
`timescale 1ns/100ps
`default_nettype none
module tb_clock_monitor_stop_reset_gen;
  import ccmsr_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic ext_reset_n_in = 1'b1;
  logic stop_req_in = 1'b0;
  logic wait_in = 1'b0;
  logic wakeup_in = 1'b0;
  logic osc_alive = 1'b1;
  logic clr = 1'b0;
  logic [7:0] reg_rdata_out;
  logic osc_clk, pll_clk, core_en, bus_en, ext_clk, pll_en, pll_min;
  logic osc_en, voltage_regulator_lp, tick_run, wdog_run, int_rst, cm_vec, self_clock_mode, scm_wk;
  logic stop_act;
  int osc_ticks, core_cnt, bus_cnt, ext_cnt;
  int errors = 0;
  int cmp_count = 0;
  int regs[2];
  int p;
  always #4 mclk_in = ~mclk_in;
  ccmsr_clock_gen #(.QC_LEN(8)) DUT (
    .mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .osc_clk_in(osc_clk), .pll_clk_in(pll_clk),
    .ext_reset_n_in(ext_reset_n_in), .stop_req_in(stop_req_in),
    .wait_in(wait_in), .wakeup_in(wakeup_in), .core_clk_en_out(core_en),
    .bus_clk_en_out(bus_en), .ext_bus_clk_out(ext_clk),
    .pll_enable_out(pll_en), .pll_min_freq_out(pll_min),
    .osc_enable_out(osc_en), .voltage_regulator_low_power_out(voltage_regulator_lp),
    .tick_run_out(tick_run), .watchdog_run_out(wdog_run),
    .internal_reset_out(int_rst), .cm_vector_out(cm_vec),
    .self_clock_mode_out(self_clock_mode), .scm_wakeup_out(scm_wk),
    .stop_active_out(stop_act));
  ccmsr_far_model far (
    .mclk_in(mclk_in), .osc_alive_in(osc_alive), .osc_en_in(osc_en),
    .pll_en_in(pll_en), .clr_in(clr),
    .core_en_in(core_en), .bus_en_in(bus_en), .ext_clk_in(ext_clk),
    .osc_clk_out(osc_clk), .pll_clk_out(pll_clk),
    .osc_ticks_out(osc_ticks), .core_cnt_out(core_cnt),
    .bus_cnt_out(bus_cnt), .ext_cnt_out(ext_cnt));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  // Synchronisers blur tick counts by a couple of ticks either way.
  function automatic logic [7:0] near(input int a, input int b);
    return 8'(a - b >= -2 && a - b <= 2);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    if (a < 4'h2) regs[a] = int'(v);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m,
                    input logic [7:0] e, input string nm);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(nm, reg_rdata_out & m, e);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return int_rst;
      1: return self_clock_mode;
      default: return stop_act;
    endcase
  endfunction
  task automatic wfor(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(s) !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        chk("wait limit", 8'(s), 8'hff);
        close_out();
      end
    end
  endtask
  task automatic win(input int n);
    @(posedge mclk_in);
    clr <= 1'b1;
    @(posedge mclk_in);
    clr <= 1'b0;
    cyc(n);
  endtask
  task automatic pulse(input logic stp);
    @(posedge mclk_in);
    if (stp) stop_req_in <= 1'b1;
    else wakeup_in <= 1'b1;
    @(posedge mclk_in);
    stop_req_in <= 1'b0;
    wakeup_in <= 1'b0;
    wfor(2, stp, 100);
    regs[0] = regs[0] & 8'hfe;
  endtask
  initial begin
    void'($urandom(6639));
    regs[0] = 8'h0e;
    regs[1] = 0;
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    clr <= 1'b1;
    @(posedge mclk_in);
    clr <= 1'b0;
    rd(4'h0, 8'hff, 8'(regs[0]), "ctrl reset");
    rd(4'h1, 8'hff, 8'h00, "pstop reset");
    rd(4'h7, 8'hff, 8'h00, "unmapped");
    wfor(0, 1'b0, 3000);
    chk("reset len", 8'(osc_ticks >= 191 && osc_ticks <= 195), 8'h01);
    chk("cm vector", 8'(cm_vec), 8'h00);
    $display("test 1 done");
    win(500);
    chk("core vs bus", near(core_cnt, 2 * bus_cnt), 8'h01);
    chk("core vs osc", near(core_cnt, osc_ticks), 8'h01);
    chk("ext vs core", near(ext_cnt, core_cnt), 8'h01);
    $display("test 2 done");
    wr(4'h0, 8'h0f);
    cyc(60);
    rd(4'h2, 8'h10, 8'h10, "on pll");
    wr(4'h0, 8'h0d);
    cyc(5);
    chk("pll held", 8'(pll_en), 8'h01);
    wr(4'h0, 8'h0f);
    cyc(60);
    pulse(1'b1);
    rd(4'h0, 8'hff, 8'(regs[0]), "ctrl in stop");
    chk("pll off", 8'(pll_en), 8'h00);
    chk("osc off", 8'(osc_en), 8'h00);
    chk("voltage_regulator low", 8'(voltage_regulator_lp), 8'h01);
    win(60);
    chk("stop clocks", 8'(core_cnt + bus_cnt + ext_cnt), 8'h00);
    pulse(1'b0);
    $display("test 3 done");
    repeat (2) begin
      p = int'($urandom % 4);
      wr(4'h1, 8'(p));
      wr(4'h0, 8'h4c);
      pulse(1'b1);
      chk("osc pseudo", 8'(osc_en), 8'h01);
      chk("tick run", 8'(tick_run), 8'(p & 1));
      chk("wdog run", 8'(wdog_run), 8'(p >> 1));
      rd(4'h1, 8'h03, 8'(regs[1]), "pstop");
      pulse(1'b0);
    end
    $display("test 4 done");
    wr(4'h0, 8'h08);
    osc_alive <= 1'b0;
    cyc(400);
    chk("no scm", 8'(self_clock_mode), 8'h00);
    chk("no reset", 8'(int_rst), 8'h00);
    osc_alive <= 1'b1;
    cyc(20);
    $display("test 5 done");
    @(posedge mclk_in);
    wait_in <= 1'b1;
    wr(4'h0, 8'h2e);
    osc_alive <= 1'b0;
    wfor(1, 1'b1, 400);
    chk("pll wait", 8'(pll_en), 8'h01);
    chk("pll min", 8'(pll_min), 8'h01);
    chk("voltage_regulator wait", 8'(voltage_regulator_lp), 8'h00);
    chk("no wake", 8'(scm_wk), 8'h00);
    rd(4'h2, 8'h01, 8'h01, "scm flag");
    wr(4'h0, 8'h3e);
    cyc(2);
    chk("scm wake", 8'(scm_wk), 8'h01);
    osc_alive <= 1'b1;
    wfor(1, 1'b0, 300);
    cyc(4);
    chk("pll wai", 8'(pll_en), 8'h00);
    rd(4'h2, 8'h04, 8'h04, "osc good");
    wr(4'h2, 8'h01);
    cyc(2);
    chk("wake clr", 8'(scm_wk), 8'h00);
    @(posedge mclk_in);
    wait_in <= 1'b0;
    $display("test 6 done");
    wr(4'h0, 8'h06);
    osc_alive <= 1'b0;
    wfor(0, 1'b1, 400);
    regs[0] = 8'h0e;
    chk("cm scm", 8'(self_clock_mode), 8'h01);
    rd(4'h0, 8'hff, 8'(regs[0]), "ctrl dflt");
    osc_alive <= 1'b1;
    wfor(1, 1'b0, 300);
    chk("rst running", 8'(int_rst), 8'h01);
    wfor(0, 1'b0, 3000);
    chk("cm vector", 8'(cm_vec), 8'h01);
    rd(4'h2, 8'h08, 8'h08, "cm fail");
    $display("test 7 done");
    wr(4'h0, 8'h4e);
    osc_alive <= 1'b0;
    wfor(1, 1'b1, 400);
    pulse(1'b1);
    chk("pll pseudo scm", 8'(pll_en), 8'h01);
    chk("voltage_regulator pseudo scm", 8'(voltage_regulator_lp), 8'h00);
    osc_alive <= 1'b1;
    wfor(1, 1'b0, 300);
    pulse(1'b0);
    wr(4'h0, 8'h0e);
    osc_alive <= 1'b0;
    wfor(1, 1'b1, 400);
    pulse(1'b1);
    osc_alive <= 1'b1;
    cyc(50);
    chk("scm in stop", 8'(self_clock_mode), 8'h01);
    pulse(1'b0);
    wfor(1, 1'b0, 300);
    $display("test 8 done");
    @(posedge mclk_in);
    ext_reset_n_in <= 1'b0;
    cyc(1600);
    chk("ext hold", 8'(int_rst), 8'h01);
    @(posedge mclk_in);
    ext_reset_n_in <= 1'b1;
    wfor(0, 1'b0, 3000);
    chk("vec clear", 8'(cm_vec), 8'h00);
    rd(4'h0, 8'hff, 8'(regs[0]), "ctrl ext");
    $display("test 9 done");
    close_out();
  end
endmodule // tb_clock_monitor_stop_reset_gen
`default_nettype wire
